// >>> common/timer_channel_consts.svh
// constants for the timer channel configuration block: offsets, fields, reset values, divider widths
`ifndef TIMER_CHANNEL_CONSTS_SVH
`define TIMER_CHANNEL_CONSTS_SVH

// register offsets, one byte per register
`define ADDR_TCR_BASE 8'h00
`define ADDR_MODE_BASE 8'h06
`define ADDR_PINC_BASE 8'h0C
`define ADDR_RUN 8'h14

// register counts
`define NUM_CH 6
`define NUM_PINC 8

// reset values
`define TCR_RESET 8'h00
`define MODE_RESET 8'hC0
`define MODE_STORE_RESET 6'h00
`define PINC_RESET 8'h00
`define RUN_RESET 6'h00
`define MODE_FIXED_ONES 2'h3

// write masks
`define MODE_WMASK_BUF 6'h3F
`define MODE_WMASK_NOBUF 6'h0F
`define TCR_WMASK_FULL 8'hFF
`define TCR_WMASK_NO7 8'h7F

// field positions
`define MODE_BUF_B_BIT 5
`define MODE_BUF_A_BIT 4
`define PINC_INIT_BIT 2
`define PINC_CAPT_BIT 3

// prescaler: low bits that must be all ones for each ratio
`define PRESCALE_BITS 12
`define DIV4_BITS 2
`define DIV16_BITS 4
`define DIV64_BITS 6
`define DIV256_BITS 8
`define DIV1024_BITS 10
`define DIV4096_BITS 12

// counter
`define CNT_WIDTH 16
`define CNT_MAX 16'hFFFF

`endif

// >>> common/timer_channel_pkg.sv
// types shared by the timer channel configuration block
package timer_channel_pkg;

  // operating mode field encodings
  typedef enum logic [3:0] {
    MODE_NORMAL = 4'h0,
    MODE_RSVD = 4'h1,
    MODE_PWM1 = 4'h2,
    MODE_PWM2 = 4'h3,
    MODE_PHASE1 = 4'h4,
    MODE_PHASE2 = 4'h5,
    MODE_PHASE3 = 4'h6,
    MODE_PHASE4 = 4'h7
  } op_mode_t;

  // count clock sources after clock select decode
  typedef enum logic [3:0] {
    SRC_DIV1 = 4'h0,
    SRC_DIV4 = 4'h1,
    SRC_DIV16 = 4'h2,
    SRC_DIV64 = 4'h3,
    SRC_DIV256 = 4'h4,
    SRC_DIV1024 = 4'h5,
    SRC_DIV4096 = 4'h6,
    SRC_EXT_A = 4'h7,
    SRC_EXT_B = 4'h8,
    SRC_EXT_C = 4'h9,
    SRC_EXT_D = 4'hA,
    SRC_OVF2 = 4'hB,
    SRC_OVF5 = 4'hC
  } clk_src_t;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // decoded per-channel configuration
  typedef struct packed {
    op_mode_t op_mode;
    logic phase;
    logic buf_a;
    logic buf_b;
    logic capcmp_c_en;
    logic capcmp_d_en;
    logic [3:0] func_c;
    logic [3:0] func_d;
  } chan_cfg_t;

endpackage : timer_channel_pkg

// >>> dv/timer_channel_cfg_bench.sv
// self-checking bench for the timer channel configuration block
`include "timer_channel_consts.svh"

module timer_channel_cfg_bench
  import timer_channel_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk;
  logic rstn;
  logic hw_standby;
  bus_req_t req;
  logic [7:0] rdata;
  logic [3:0] ext;
  logic [5:0] count_tick;
  logic [5:0] cnt_ovf;
  logic [5:0][1:0] pin_out;
  logic [5:0][1:0] pin_oe_n;
  chan_cfg_t [5:0] chan_cfg;
  logic [7:0] exp_q[$];
  logic rd_pend;
  logic [31:0] seed;
  logic [7:0] pc;
  logic [7:0] ex[20];
  logic [7:0] d;
  int miscompares;
  int checked;
  int tk[6];
  int ovf2;
  // tick period per channel and code: pins a-d have periods 2, 8, 32, 128; 0 means cascade
  int per_t[6][8] = '{'{1, 4, 16, 64, 2, 8, 32, 128}, '{1, 4, 16, 64, 2, 8, 256, 0},
                      '{1, 4, 16, 64, 2, 8, 32, 1024}, '{1, 4, 16, 64, 2, 1024, 256, 4096},
                      '{1, 4, 16, 64, 2, 32, 1024, 0}, '{1, 4, 16, 64, 2, 32, 256, 128}};
  // windows are multiples of every period in use, so prescaler phase drops out
  int wins[8] = '{256, 256, 256, 256, 256, 1024, 1024, 4096};

  timer_channel_cfg dut (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .hw_standby(hw_standby),
    .req(req),
    .rdata(rdata),
    .ext_clock_pin_a(ext[0]),
    .ext_clock_pin_b(ext[1]),
    .ext_clock_pin_c(ext[2]),
    .ext_clock_pin_d(ext[3]),
    .count_tick(count_tick),
    .cnt_ovf(cnt_ovf),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .chan_cfg(chan_cfg)
  );

  // 100 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // free-running pin pattern, periodic so tick counts are exact
  always @(posedge sys_clk) begin
    pc <= pc + 8'h01;
    ext <= {pc[6], pc[4], pc[2], pc[0]};
  end

  // read monitor: rdata is only valid the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_pend) begin
      if (exp_q.size() > 0) begin
        cmp({8'h00, rdata}, {8'h00, exp_q.pop_front()});
      end else begin
        cmp({8'h00, rdata}, 16'hFFFF); // no note queued: always a mismatch
      end
    end
    rd_pend <= (req.rd === 1'b1);
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // one strobe cycle, then an idle cycle so no signal is driven twice in a step
  task automatic bus(input logic [7:0] a, input logic [7:0] dat, input logic w);
    req <= '{addr: a, wdata: dat, wr: w, rd: ~w};
    @(posedge sys_clk);
    req <= '{addr: a, wdata: dat, wr: 1'b0, rd: 1'b0};
    @(posedge sys_clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    bus(a, dat, 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(a, 8'h00, 1'b0);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  // count ticks per channel and channel 2 wraps over a fixed window
  task automatic win(input int n);
    tk = '{default: 0};
    ovf2 = 0;
    repeat (n) begin
      @(posedge sys_clk);
      for (int c = 0; c < 6; c++) begin
        if (count_tick[c] === 1'b1) tk[c]++;
      end
      if (cnt_ovf[2] === 1'b1) ovf2++;
    end
  endtask : win

  task automatic defaults();
    for (int a = 0; a <= 8'h15; a++) begin
      rd(8'(a), (a >= `ADDR_MODE_BASE && a < `ADDR_PINC_BASE) ? `MODE_RESET : 8'h00);
    end
    rd(8'hFF, 8'h00);
  endtask : defaults

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // main sequence
  initial begin
    rstn = 1'b0;
    hw_standby = 1'b0;
    req = '0;
    ext = 4'h0;
    pc = 8'h00;
    rd_pend = 1'b0;
    seed = 32'hB80B4E58;
    miscompares = 0;
    checked = 0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    defaults();
    // random fill; mode writes keep the top mode bit and, on 0 and 3, bit 2 clear
    for (int a = 0; a < 20; a++) begin
      d = 8'(xs());
      if (a < 6) begin
        ex[a] = (a == 0 || a == 3) ? d : d & 8'h7F;
      end else if (a < 12) begin
        d = (a == 6 || a == 9) ? d & 8'h33 : d & 8'hF7;
        ex[a] = 8'hC0 | (d & ((a == 6 || a == 9) ? 8'h33 : 8'h07));
      end else begin
        ex[a] = d;
      end
      wr(8'(a), d);
    end
    wr(8'h20, 8'hFF);
    for (int a = 0; a < 20; a++) begin
      rd(8'(a), ex[a]);
    end
    rd(8'h20, 8'h00);
    // standby clears everything written above
    hw_standby <= 1'b1;
    @(posedge sys_clk);
    hw_standby <= 1'b0;
    @(posedge sys_clk);
    defaults();
    // clock select sweep, all channels at once, counters stopped
    for (int c = 0; c < 8; c++) begin
      for (int ch = 0; ch < 6; ch++) wr(8'(`ADDR_TCR_BASE + ch), 8'(c));
      cyc(8);
      win(wins[c]);
      for (int ch = 0; ch < 6; ch++) begin
        cmp(16'(tk[ch]), 16'(per_t[ch][c] == 0 ? 0 : wins[c] / per_t[ch][c]));
      end
    end
    // phase counting silences the selected clock on 1, 2, 4, 5
    for (int ch = 0; ch < 6; ch++) wr(8'(`ADDR_TCR_BASE + ch), 8'h00);
    for (int ch = 0; ch < 6; ch++) wr(8'(`ADDR_MODE_BASE + ch), (ch == 0 || ch == 3) ? 8'h00 : 8'h04);
    cyc(4);
    win(256);
    for (int ch = 0; ch < 6; ch++) cmp(16'(tk[ch]), (ch == 0 || ch == 3) ? 16'd256 : 16'd0);
    // every operating mode code, reserved one included
    for (int c = 0; c < 8; c++) begin
      wr(8'(`ADDR_MODE_BASE + 1), 8'(c));
      cyc(3);
      cmp({12'h000, chan_cfg[1].op_mode}, 16'(c));
      cmp({15'h0000, chan_cfg[1].phase}, 16'(c >= 4));
    end
    // buffer pairing silences C and D compare
    wr(`ADDR_MODE_BASE, 8'h30);
    wr(8'(`ADDR_MODE_BASE + 3), 8'h10);
    wr(8'h0D, 8'h11);
    wr(8'h11, 8'h11);
    cyc(3);
    cmp({12'h000, chan_cfg[0].buf_a, chan_cfg[0].buf_b, chan_cfg[0].capcmp_c_en, chan_cfg[0].capcmp_d_en},
        16'h000C);
    cmp({12'h000, chan_cfg[3].buf_a, chan_cfg[3].buf_b, chan_cfg[3].capcmp_c_en, chan_cfg[3].capcmp_d_en},
        16'h0009);
    cmp({4'h0, chan_cfg[0].func_d, chan_cfg[3].func_c, chan_cfg[3].func_d}, 16'h0001);
    // initial levels on a stopped channel
    wr(`ADDR_PINC_BASE, 8'h05);
    cyc(3);
    cmp({12'h000, pin_out[0], pin_oe_n[0]}, 16'h0006);
    wr(`ADDR_PINC_BASE, 8'h61);
    cyc(3);
    cmp({12'h000, pin_out[0], pin_oe_n[0]}, 16'h0008);
    // cascade and PWM mode 2: channels 2 and 5 wrap once at /1
    wr(8'(`ADDR_MODE_BASE + 1), 8'h00);
    wr(8'(`ADDR_MODE_BASE + 2), 8'h03);
    wr(8'(`ADDR_MODE_BASE + 4), 8'h00);
    wr(8'(`ADDR_MODE_BASE + 5), 8'h00);
    wr(8'(`ADDR_TCR_BASE + 1), 8'h07);
    wr(8'(`ADDR_TCR_BASE + 4), 8'h07);
    wr(8'h0F, 8'h05);
    cyc(3);
    cmp({14'h0000, pin_out[2][0], pin_oe_n[2][0]}, 16'h0002);
    wr(`ADDR_RUN, 8'h24);
    wr(8'h0F, 8'h01);
    cyc(3);
    cmp({14'h0000, pin_out[2][0], pin_oe_n[2][0]}, 16'h0002);
    win(66000);
    cmp(16'(ovf2), 16'd1);
    cmp(16'(tk[1]), 16'd1);
    cmp(16'(tk[4]), 16'd1);
    cmp({14'h0000, pin_out[2][0], pin_oe_n[2][0]}, 16'h0000);
    cyc(2);
    end_sim();
  end
endmodule : timer_channel_cfg_bench

// >>> hdl/timer_channel_cfg.sv
// six-channel timer configuration: clock select, mode and pin control registers, counters
// What this block does, and what software must keep to
// [R1] codes 0-3 count on clock /1 /4 /16 /64
// [R2] channel 0 codes 4-7 pick pins A-D
// [R3] channel 1: A, B, /256, channel 2 overflow
// [R4] channel 2: A, B, C, then /1024
// [R5] channel 3: A, then /1024 /256 /4096
// [R6] channel 4: A, C, /1024, channel 5 overflow
// [R7] channel 5: A, C, /256, then pin D
// [R8] phase counting overrides clock select on 1,2,4,5
// [R9] mode register resets 0xC0, top bits one
// [R10] software writes mode only while stopped
// [R11] bit 5 buffers B with D, D silenced
// [R12] bit 4 buffers A with C, C silenced
// [R13] channels 1,2,4,5 bits 5,4 read zero
// [R14] mode field decodes normal, PWM, phase modes
// [R15] software writes zero to mode top bit
// [R16] software keeps bit 2 zero on 0,3
// [R17] channels 0,3 two pin registers, others one
// [R18] pin registers reset to zero
// [R19] buffered C or D ignores pin setting
// [R20] initial level driven while counter stopped
// [R21] PWM mode 2 drives initial level at clear
// [R22] clock select is bits 2-0 per channel
// [R23] cascaded channel counts once per overflow
`include "timer_channel_consts.svh"

module timer_channel_cfg
  import timer_channel_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic hw_standby,
  // register bus
  input wire bus_req_t req,
  output logic [7:0] rdata,
  // external count clock pins
  input wire logic ext_clock_pin_a,
  input wire logic ext_clock_pin_b,
  input wire logic ext_clock_pin_c,
  input wire logic ext_clock_pin_d,
  // counter events
  output logic [5:0] count_tick,
  output logic [5:0] cnt_ovf,
  // pin A/B drive, enable low while driving
  output logic [5:0][1:0] pin_out,
  output logic [5:0][1:0] pin_oe_n,
  // decoded configuration
  output chan_cfg_t [5:0] chan_cfg
);

  // mode bits that software can change, per channel
  function automatic logic [5:0] mode_wmask(input int ch);
    return (ch == 0 || ch == 3) ? `MODE_WMASK_BUF : `MODE_WMASK_NOBUF;
  endfunction : mode_wmask

  // bit 7 of the timer control register is reserved outside channels 0 and 3
  function automatic logic [7:0] tcr_wmask(input int ch);
    return (ch == 0 || ch == 3) ? `TCR_WMASK_FULL : `TCR_WMASK_NO7;
  endfunction : tcr_wmask

  // index of the pin control register that serves pins A and B
  function automatic int pinc_hi_idx(input int ch);
    case (ch)
      0: return 0;
      1: return 2;
      2: return 3;
      3: return 4;
      4: return 6;
      default: return 7;
    endcase
  endfunction : pinc_hi_idx

  // clock select decode, different upper half for every channel
  function automatic clk_src_t clk_src(input int ch, input logic [2:0] cs);
    if (!cs[2]) begin
      return clk_src_t'({2'h0, cs[1:0]}); // [R1]
    end
    case (ch)
      0: return clk_src_t'(4'(SRC_EXT_A + cs[1:0])); // [R2]
      1: case (cs[1:0]) // [R3]
           2'h0: return SRC_EXT_A;
           2'h1: return SRC_EXT_B;
           2'h2: return SRC_DIV256;
           default: return SRC_OVF2;
         endcase
      2: case (cs[1:0]) // [R4]
           2'h0: return SRC_EXT_A;
           2'h1: return SRC_EXT_B;
           2'h2: return SRC_EXT_C;
           default: return SRC_DIV1024;
         endcase
      3: case (cs[1:0]) // [R5]
           2'h0: return SRC_EXT_A;
           2'h1: return SRC_DIV1024;
           2'h2: return SRC_DIV256;
           default: return SRC_DIV4096;
         endcase
      4: case (cs[1:0]) // [R6]
           2'h0: return SRC_EXT_A;
           2'h1: return SRC_EXT_C;
           2'h2: return SRC_DIV1024;
           default: return SRC_OVF5;
         endcase
      default: case (cs[1:0]) // [R7]
           2'h0: return SRC_EXT_A;
           2'h1: return SRC_EXT_C;
           2'h2: return SRC_DIV256;
           default: return SRC_EXT_D;
         endcase
    endcase
  endfunction : clk_src

  // register storage
  logic [7:0] tcr_reg [`NUM_CH];
  logic [5:0] mode_reg [`NUM_CH];
  logic [7:0] pinc_reg [`NUM_PINC];
  logic [5:0] run_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // timing state
  logic [`PRESCALE_BITS-1:0] prescale_reg;
  logic [3:0] ext_prev_reg;
  logic [`CNT_WIDTH-1:0] cnt_reg [`NUM_CH];
  logic [5:0] tick_reg;
  logic [5:0] ovf_reg;
  logic [5:0][1:0] pin_out_reg;
  logic [5:0][1:0] pin_oe_n_reg;
  chan_cfg_t [5:0] cfg_reg;

  // source ticks, one bit per clk_src_t value
  logic [12:0] src_tick;
  logic [3:0] ext_now;
  logic run_wr;

  assign ext_now = {ext_clock_pin_d, ext_clock_pin_c, ext_clock_pin_b, ext_clock_pin_a};
  assign run_wr = req.wr && (req.addr == `ADDR_RUN);

  // prescaler taps: one pulse per N clocks, all but /1 from one free-running count
  assign src_tick[SRC_DIV1] = 1'b1; // [R1]
  assign src_tick[SRC_DIV4] = &prescale_reg[`DIV4_BITS-1:0];
  assign src_tick[SRC_DIV16] = &prescale_reg[`DIV16_BITS-1:0];
  assign src_tick[SRC_DIV64] = &prescale_reg[`DIV64_BITS-1:0];
  assign src_tick[SRC_DIV256] = &prescale_reg[`DIV256_BITS-1:0];
  assign src_tick[SRC_DIV1024] = &prescale_reg[`DIV1024_BITS-1:0];
  assign src_tick[SRC_DIV4096] = &prescale_reg[`DIV4096_BITS-1:0];
  // pins count on the rising edge; edge selection lives outside this block
  assign src_tick[SRC_EXT_D:SRC_EXT_A] = ext_now & ~ext_prev_reg;
  // cascade taps use the registered overflow pulse, so one event gives one tick
  assign src_tick[SRC_OVF2] = ovf_reg[2]; // [R23]
  assign src_tick[SRC_OVF5] = ovf_reg[5]; // [R23]

  // prescaler and pin history
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prescale_reg <= '0;
      ext_prev_reg <= 4'h0;
    end else begin
      prescale_reg <= prescale_reg + `PRESCALE_BITS'(1);
      ext_prev_reg <= ext_now;
    end
  end

  // counter run bits, own register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      run_reg <= `RUN_RESET;
    end else if (hw_standby) begin
      run_reg <= `RUN_RESET;
    end else if (run_wr) begin
      run_reg <= req.wdata[5:0];
    end
  end

  // pin control registers, standby clears them like reset
  for (genvar j = 0; j < `NUM_PINC; j++) begin : g_pinc
    logic pinc_wr;
    assign pinc_wr = req.wr && (req.addr == 8'(`ADDR_PINC_BASE + j));
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        pinc_reg[j] <= `PINC_RESET; // [R18]
      end else if (hw_standby) begin
        pinc_reg[j] <= `PINC_RESET; // [R18]
      end else if (pinc_wr) begin
        pinc_reg[j] <= req.wdata; // [R17]
      end
    end
  end

  // per-channel registers, clock select, counter and pins
  for (genvar ch = 0; ch < `NUM_CH; ch++) begin : g_ch
    logic tcr_wr;
    logic mode_wr;
    logic phase;
    logic tick;
    logic inc;
    logic ovf_now;
    logic [7:0] pinc_ab;
    logic [7:0] pinc_cd;
    logic has_cd;
    clk_src_t src;
    op_mode_t mode;

    assign tcr_wr = req.wr && (req.addr == 8'(`ADDR_TCR_BASE + ch));
    assign mode_wr = req.wr && (req.addr == 8'(`ADDR_MODE_BASE + ch));
    assign mode = op_mode_t'(mode_reg[ch][3:0]); // [R14]
    // phase counting is not available on channels 0 and 3
    assign has_cd = (ch == 0 || ch == 3);
    assign phase = !has_cd && (mode_reg[ch][3:2] == 2'h1); // [R14]
    assign src = clk_src(ch, tcr_reg[ch][2:0]); // [R22]
    // the phase decoder is not part of this block, so the tick goes quiet
    assign tick = !phase && src_tick[src]; // [R8]
    assign inc = run_reg[ch] && tick_reg[ch];
    assign ovf_now = inc && (cnt_reg[ch] == `CNT_MAX);
    assign pinc_ab = pinc_reg[pinc_hi_idx(ch)];
    // modulo keeps the unused index in range on channel 5
    assign pinc_cd = has_cd ? pinc_reg[(pinc_hi_idx(ch) + 1) % `NUM_PINC] : 8'h00;

    // timer control and mode registers
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        tcr_reg[ch] <= `TCR_RESET;
        mode_reg[ch] <= `MODE_STORE_RESET; // [R9]
      end else if (hw_standby) begin
        tcr_reg[ch] <= `TCR_RESET;
        mode_reg[ch] <= `MODE_STORE_RESET; // [R9]
      end else begin
        if (tcr_wr) begin
          tcr_reg[ch] <= req.wdata & tcr_wmask(ch);
        end
        // reserved buffer bits never store on channels without C and D
        if (mode_wr) begin
          mode_reg[ch] <= req.wdata[5:0] & mode_wmask(ch); // [R13]
        end
      end
    end

    // count clock pipeline and counter; counting stops while the run bit is low
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        tick_reg[ch] <= 1'b0;
        ovf_reg[ch] <= 1'b0;
        cnt_reg[ch] <= '0;
      end else begin
        tick_reg[ch] <= tick;
        ovf_reg[ch] <= ovf_now; // [R23]
        if (inc) begin
          cnt_reg[ch] <= cnt_reg[ch] + `CNT_WIDTH'(1);
        end
      end
    end

    // decoded configuration; buffered C or D loses capture and compare
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        cfg_reg[ch] <= '0;
      end else begin
        cfg_reg[ch].op_mode <= mode;
        cfg_reg[ch].phase <= phase;
        cfg_reg[ch].buf_a <= mode_reg[ch][`MODE_BUF_A_BIT]; // [R12]
        cfg_reg[ch].buf_b <= mode_reg[ch][`MODE_BUF_B_BIT]; // [R11]
        cfg_reg[ch].capcmp_c_en <= has_cd && !mode_reg[ch][`MODE_BUF_A_BIT]; // [R12]
        cfg_reg[ch].capcmp_d_en <= has_cd && !mode_reg[ch][`MODE_BUF_B_BIT]; // [R11]
        cfg_reg[ch].func_c <= mode_reg[ch][`MODE_BUF_A_BIT] ? 4'h0 : pinc_cd[3:0]; // [R19]
        cfg_reg[ch].func_d <= mode_reg[ch][`MODE_BUF_B_BIT] ? 4'h0 : pinc_cd[7:4]; // [R19]
      end
    end

    // pins A (low nibble) and B (high nibble)
    for (genvar p = 0; p < 2; p++) begin : g_pin
      logic [3:0] fld;
      logic is_out;
      assign fld = pinc_ab[4*p +: 4];
      // output compare with a defined initial level
      assign is_out = !fld[`PINC_CAPT_BIT] && (fld[1:0] != 2'h0);
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          pin_out_reg[ch][p] <= 1'b0;
          pin_oe_n_reg[ch][p] <= 1'b1;
        end else if (!run_reg[ch]) begin
          pin_out_reg[ch][p] <= fld[`PINC_INIT_BIT]; // [R20]
          pin_oe_n_reg[ch][p] <= !is_out; // [R20]
        end else if (mode == MODE_PWM2 && ovf_now && is_out) begin
          // counter wraps to zero here, which is the clear point
          pin_out_reg[ch][p] <= fld[`PINC_INIT_BIT]; // [R21]
        end
      end
    end
  end

  // read decode; the 8-bit index math is safe since all offsets sit below 0x20
  logic [7:0] tcr_off;
  logic [7:0] mode_off;
  logic [7:0] pinc_off;
  assign tcr_off = req.addr - `ADDR_TCR_BASE;
  assign mode_off = req.addr - `ADDR_MODE_BASE;
  assign pinc_off = req.addr - `ADDR_PINC_BASE;

  always_comb begin
    rdata_next = 8'h00;
    if (req.addr < `ADDR_MODE_BASE) begin
      rdata_next = tcr_reg[tcr_off[2:0]];
    end else if (req.addr < `ADDR_PINC_BASE) begin
      rdata_next = {`MODE_FIXED_ONES, mode_reg[mode_off[2:0]]}; // [R9]
    end else if (req.addr < `ADDR_RUN) begin
      rdata_next = pinc_reg[pinc_off[2:0]];
    end else if (req.addr == `ADDR_RUN) begin
      rdata_next = {2'h0, run_reg};
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= req.rd ? rdata_next : 8'h00;
    end
  end

  assign rdata = rdata_reg;
  assign count_tick = tick_reg;
  assign cnt_ovf = ovf_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe_n = pin_oe_n_reg;
  assign chan_cfg = cfg_reg;

  // checks on the behaviour above
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_div4_held;
    (tcr_reg[0][2:0] == 3'h1) [*5];
  endsequence

  sequence s_ch1_phase_held;
    (mode_reg[1][3:2] == 2'h1) [*2];
  endsequence

  AST_MODE_TOP_ONES: assert property ( // [R9]
    (req.rd && req.addr == `ADDR_MODE_BASE) |=> (rdata[7:6] == 2'h3))
    else $error("mode register top bits did not read as one");

  AST_RSVD_BUF_BITS: assert property ( // [R13]
    (req.rd && req.addr == 8'(`ADDR_MODE_BASE + 1)) |=> (rdata[5:4] == 2'h0))
    else $error("reserved buffer bits read nonzero");

  // the edge that releases reset still finds the tick flop held
  AST_DIV1_EVERY_CYCLE: assert property ( // [R1]
    (rstn && tcr_reg[0][2:0] == 3'h0) |=> count_tick[0])
    else $error("divide by one source missed a cycle");

  AST_DIV4_SPACING: assert property ( // [R1]
    s_div4_held ##0 count_tick[0] |-> !$past(count_tick[0], 1) && !$past(count_tick[0], 2)
      && !$past(count_tick[0], 3))
    else $error("divide by four ticks too close");

  AST_CH0_PIN_A: assert property ( // [R2]
    (tcr_reg[0][2:0] == 3'h4 && ext_clock_pin_a && !ext_prev_reg[0]) |=> count_tick[0])
    else $error("channel 0 missed pin A edge");

  AST_CH1_CASCADE: assert property ( // [R3]
    (tcr_reg[1][2:0] == 3'h7 && mode_reg[1][3:2] != 2'h1) |=> (count_tick[1] == $past(cnt_ovf[2])))
    else $error("channel 1 cascade tick not matched to channel 2 overflow");

  AST_PHASE_OVERRIDE: assert property ( // [R8]
    s_ch1_phase_held |-> !count_tick[1])
    else $error("channel 1 counted from clock select in phase mode");

  AST_STOPPED_INIT_LEVEL: assert property ( // [R20]
    (!run_reg[0] && !pinc_reg[0][3] && pinc_reg[0][1:0] != 2'h0) [*2]
      |-> (!pin_oe_n[0][0] && pin_out[0][0] == $past(pinc_reg[0][2])))
    else $error("stopped channel did not drive initial level");

  AST_BUF_C_SILENCED: assert property ( // [R12]
    mode_reg[0][4] |=> (!chan_cfg[0].capcmp_c_en && chan_cfg[0].func_c == 4'h0))
    else $error("buffered C still active");

  AST_STANDBY_CLEARS: assert property ( // [R18]
    hw_standby |=> (pinc_reg[0] == 8'h00 && mode_reg[3] == 6'h00))
    else $error("standby did not clear registers");

endmodule : timer_channel_cfg
